// *** logic/pmbtrp_pkg.sv ***
`default_nettype none

package pmbtrp_pkg;

   localparam int ADDR_W = 7;
   localparam int STRAP_W = 4;
   localparam int DATA_W = 8;
   localparam int PTR_W = 8;
   localparam int MEM_DEPTH = 256;
   localparam int BIT_CNT_W = 4;

   localparam logic [2:0] ADDR_PREFIX = 3'h1;
   localparam logic [BIT_CNT_W-1:0] BITS_PER_BYTE = 4'h8;
   localparam logic [BIT_CNT_W-1:0] BIT_CNT_RST = 4'h0;
   localparam logic [BIT_CNT_W-1:0] BIT_CNT_ONE = 4'h1;
   localparam logic DIR_WRITE = 1'b0;
   localparam logic DIR_READ = 1'b1;
   localparam int DIR_BIT = 0;
   localparam int MSB_BIT = 7;

   localparam logic [DATA_W-1:0] DATA_RST = 8'h00;
   localparam logic [PTR_W-1:0] PTR_RST = 8'h00;
   localparam logic [STRAP_W-1:0] STRAP_RST = 4'h0;

   typedef enum logic [3:0] {
      ST_IDLE = 4'b0000,
      ST_ADDR = 4'b0001,
      ST_ADDR_ACK = 4'b0010,
      ST_PTR = 4'b0011,
      ST_PTR_ACK = 4'b0100,
      ST_DATA = 4'b0101,
      ST_DATA_ACK = 4'b0110,
      ST_TX = 4'b0111,
      ST_TX_ACK = 4'b1000,
      ST_IGNORE = 4'b1001
   } pmbtrp_state_t;

endpackage

`default_nettype wire

// *** logic/pmbtrp_regfile.sv ***
`timescale 1ns/100ps
`default_nettype none

module pmbtrp_regfile
   import pmbtrp_pkg::*;
(
   input wire logic clk,
   input wire logic reset_n,
   input wire logic wrEn,
   input wire logic [PTR_W-1:0] wrAddr,
   input wire logic [DATA_W-1:0] wrData,
   input wire logic [PTR_W-1:0] rdAddr,
   output logic [DATA_W-1:0] rdData
);

   logic [DATA_W-1:0] mem [MEM_DEPTH];
   logic [DATA_W-1:0] rdData_r;
   logic [DATA_W-1:0] rdData_nxt;

   // one byte per pointer value
   always_ff @(posedge clk) begin
      if (wrEn) begin
         mem[wrAddr] <= wrData;
      end
   end

   always_comb begin
      rdData_nxt = mem[rdAddr];
   end

   always_ff @(posedge clk or negedge reset_n) begin
      if (!reset_n) begin
         rdData_r <= DATA_RST;
      end else begin
         rdData_r <= rdData_nxt;
      end
   end

   assign rdData = rdData_r;

endmodule

`default_nettype wire

// *** logic/pmbtrp_strap_capture.sv ***
`timescale 1ns/100ps
`default_nettype none

module pmbtrp_strap_capture
   import pmbtrp_pkg::*;
(
   input wire logic clk,
   input wire logic reset_n,
   input wire logic supplyUndervoltageLockout,
   input wire logic [STRAP_W-1:0] addrStrap,
   output logic [STRAP_W-1:0] strapBits,
   output logic strapValid
);

   logic [STRAP_W-1:0] strapBits_r;
   logic [STRAP_W-1:0] strapBits_nxt;
   logic strapValid_r;
   logic strapValid_nxt;

   // single capture once the supply is out of lockout, then frozen
   always_comb begin
      strapBits_nxt = strapBits_r;
      strapValid_nxt = strapValid_r;
      if (!strapValid_r && !supplyUndervoltageLockout) begin
         strapBits_nxt = addrStrap;
         strapValid_nxt = 1'b1;
      end
   end

   always_ff @(posedge clk or negedge reset_n) begin
      if (!reset_n) begin
         strapBits_r <= STRAP_RST;
         strapValid_r <= 1'b0;
      end else begin
         strapBits_r <= strapBits_nxt;
         strapValid_r <= strapValid_nxt;
      end
   end

   assign strapBits = strapBits_r;
   assign strapValid = strapValid_r;

endmodule

`default_nettype wire

// *** logic/pmbtrp_target.sv ***
`timescale 1ns/100ps
`default_nettype none

module pmbtrp_target
   import pmbtrp_pkg::*;
(
   input wire logic clk,
   input wire logic reset_n,
   input wire logic sclIn,
   input wire logic sdaIn,
   output logic sdaOut,
   output logic sdaOe,
   input wire logic supplyUndervoltageLockout,
   input wire logic [STRAP_W-1:0] addrStrap,
   output logic [ADDR_W-1:0] ownAddr,
   output logic addrValid,
   output logic busBusy,
   output logic regWrStrobe,
   output logic [PTR_W-1:0] regWrPtr,
   output logic [DATA_W-1:0] regWrData,
   output logic [PTR_W-1:0] regPtr
);

   logic [STRAP_W-1:0] strapBits;
   logic strapValid;
   logic [DATA_W-1:0] rdData;

   logic sclPrev_r;
   logic sclPrev_nxt;
   logic sdaPrev_r;
   logic sdaPrev_nxt;

   pmbtrp_state_t state_r;
   pmbtrp_state_t state_nxt;
   logic [BIT_CNT_W-1:0] bitCnt_r;
   logic [BIT_CNT_W-1:0] bitCnt_nxt;
   logic [DATA_W-1:0] shift_r;
   logic [DATA_W-1:0] shift_nxt;
   logic [DATA_W-1:0] txByte_r;
   logic [DATA_W-1:0] txByte_nxt;
   logic [PTR_W-1:0] ptr_r;
   logic [PTR_W-1:0] ptr_nxt;
   logic dir_r;
   logic dir_nxt;
   logic masterAck_r;
   logic masterAck_nxt;
   logic sdaOe_r;
   logic sdaOe_nxt;
   logic sdaOut_r;
   logic sdaOut_nxt;
   logic busBusy_r;
   logic busBusy_nxt;
   logic wrStrobe_r;
   logic wrStrobe_nxt;
   logic [PTR_W-1:0] wrPtr_r;
   logic [PTR_W-1:0] wrPtr_nxt;
   logic [DATA_W-1:0] wrData_r;
   logic [DATA_W-1:0] wrData_nxt;
   logic [ADDR_W-1:0] ownAddr_r;
   logic [ADDR_W-1:0] ownAddr_nxt;
   logic addrValid_r;
   logic addrValid_nxt;

   logic sclRise;
   logic sclFall;
   logic startCond;
   logic stopCond;
   logic byteDone;
   logic addrHit;
   logic [DATA_W-1:0] shiftIn;
   logic storeByte;

   pmbtrp_strap_capture u_strap (
      .clk(clk),
      .reset_n(reset_n),
      .supplyUndervoltageLockout(supplyUndervoltageLockout),
      .addrStrap(addrStrap),
      .strapBits(strapBits),
      .strapValid(strapValid)
   );

   // read port always follows the held pointer
   pmbtrp_regfile u_regs (
      .clk(clk),
      .reset_n(reset_n),
      .wrEn(wrStrobe_r),
      .wrAddr(wrPtr_r),
      .wrData(wrData_r),
      .rdAddr(ptr_r),
      .rdData(rdData)
   );

   // bus events from sampled lines; rate independent, only edges matter
   always_comb begin
      sclRise = sclIn & ~sclPrev_r;
      sclFall = ~sclIn & sclPrev_r;
      startCond = sclIn & sclPrev_r & sdaPrev_r & ~sdaIn;
      stopCond = sclIn & sclPrev_r & ~sdaPrev_r & sdaIn;
      byteDone = (bitCnt_r == BITS_PER_BYTE);
      shiftIn = {shift_r[DATA_W-2:0], sdaIn};
      // seven-bit compare only; first byte of 10-bit form never matches
      addrHit = addrValid_r && (shift_r[DATA_W-1:DIR_BIT+1] == ownAddr_r);
   end

   // assembled own address
   always_comb begin
      ownAddr_nxt = {ADDR_PREFIX, strapBits};
      addrValid_nxt = strapValid;
      sclPrev_nxt = sclIn;
      sdaPrev_nxt = sdaIn;
   end

   always_ff @(posedge clk or negedge reset_n) begin
      if (!reset_n) begin
         ownAddr_r <= {ADDR_PREFIX, STRAP_RST};
         addrValid_r <= 1'b0;
         sclPrev_r <= 1'b1;
         sdaPrev_r <= 1'b1;
      end else begin
         ownAddr_r <= ownAddr_nxt;
         addrValid_r <= addrValid_nxt;
         sclPrev_r <= sclPrev_nxt;
         sdaPrev_r <= sdaPrev_nxt;
      end
   end

   // protocol engine
   always_comb begin
      state_nxt = state_r;
      bitCnt_nxt = bitCnt_r;
      shift_nxt = shift_r;
      txByte_nxt = txByte_r;
      ptr_nxt = ptr_r;
      dir_nxt = dir_r;
      masterAck_nxt = masterAck_r;
      sdaOe_nxt = sdaOe_r;
      busBusy_nxt = busBusy_r;
      storeByte = 1'b0;
      // open drain: the line is only ever pulled low
      sdaOut_nxt = 1'b0;
      if (stopCond) begin
         // pointer untouched so a later read uses it
         state_nxt = ST_IDLE;
         bitCnt_nxt = BIT_CNT_RST;
         sdaOe_nxt = 1'b0;
         busBusy_nxt = 1'b0;
      end else if (startCond) begin
         // plain or repeated start, from any state
         state_nxt = ST_ADDR;
         bitCnt_nxt = BIT_CNT_RST;
         sdaOe_nxt = 1'b0;
         busBusy_nxt = 1'b1;
      end else begin
         case (state_r)
            ST_IDLE: begin
               sdaOe_nxt = 1'b0;
            end
            ST_ADDR, ST_PTR, ST_DATA: begin
               if (sclRise && !byteDone) begin
                  shift_nxt = shiftIn;
                  bitCnt_nxt = bitCnt_r + BIT_CNT_ONE;
               end else if (sclFall && byteDone) begin
                  bitCnt_nxt = BIT_CNT_RST;
                  if (state_r == ST_ADDR) begin
                     if (addrHit) begin
                        dir_nxt = shift_r[DIR_BIT];
                        sdaOe_nxt = 1'b1;
                        state_nxt = ST_ADDR_ACK;
                     end else begin
                        // foreign address: stay off the bus
                        state_nxt = ST_IGNORE;
                     end
                  end else if (state_r == ST_PTR) begin
                     ptr_nxt = shift_r;
                     sdaOe_nxt = 1'b1;
                     state_nxt = ST_PTR_ACK;
                  end else begin
                     storeByte = 1'b1;
                     sdaOe_nxt = 1'b1;
                     state_nxt = ST_DATA_ACK;
                  end
               end
            end
            ST_ADDR_ACK: begin
               if (sclFall) begin
                  if (dir_r == DIR_READ) begin
                     // first data bit goes out on the ack clock's falling edge
                     txByte_nxt = rdData;
                     sdaOe_nxt = ~rdData[MSB_BIT];
                     state_nxt = ST_TX;
                  end else begin
                     sdaOe_nxt = 1'b0;
                     state_nxt = ST_PTR;
                  end
               end
            end
            ST_PTR_ACK: begin
               if (sclFall) begin
                  sdaOe_nxt = 1'b0;
                  state_nxt = ST_DATA;
               end
            end
            ST_DATA_ACK: begin
               if (sclFall) begin
                  // a second data byte is not taken
                  sdaOe_nxt = 1'b0;
                  state_nxt = ST_IGNORE;
               end
            end
            ST_TX: begin
               if (sclRise && !byteDone) begin
                  bitCnt_nxt = bitCnt_r + BIT_CNT_ONE;
               end else if (sclFall) begin
                  if (byteDone) begin
                     bitCnt_nxt = BIT_CNT_RST;
                     sdaOe_nxt = 1'b0;
                     state_nxt = ST_TX_ACK;
                  end else begin
                     txByte_nxt = {txByte_r[DATA_W-2:0], 1'b0};
                     sdaOe_nxt = ~txByte_r[MSB_BIT-1];
                  end
               end
            end
            ST_TX_ACK: begin
               if (sclRise) begin
                  masterAck_nxt = ~sdaIn;
               end else if (sclFall) begin
                  if (masterAck_r) begin
                     // more asked for: same register again, no increment
                     txByte_nxt = rdData;
                     sdaOe_nxt = ~rdData[MSB_BIT];
                     state_nxt = ST_TX;
                  end else begin
                     state_nxt = ST_IGNORE;
                  end
               end
            end
            ST_IGNORE: begin
               sdaOe_nxt = 1'b0;
            end
            default: begin
               state_nxt = ST_IDLE;
               sdaOe_nxt = 1'b0;
            end
         endcase
      end
   end

   // store group: one strobe per accepted data byte, pointer and byte held after
   always_comb begin
      wrStrobe_nxt = storeByte;
      wrPtr_nxt = wrPtr_r;
      wrData_nxt = wrData_r;
      if (storeByte) begin
         wrPtr_nxt = ptr_r;
         wrData_nxt = shift_r;
      end
   end

   always_ff @(posedge clk or negedge reset_n) begin
      if (!reset_n) begin
         wrStrobe_r <= 1'b0;
         wrPtr_r <= PTR_RST;
         wrData_r <= DATA_RST;
      end else begin
         wrStrobe_r <= wrStrobe_nxt;
         wrPtr_r <= wrPtr_nxt;
         wrData_r <= wrData_nxt;
      end
   end

   always_ff @(posedge clk or negedge reset_n) begin
      if (!reset_n) begin
         state_r <= ST_IDLE;
         bitCnt_r <= BIT_CNT_RST;
         shift_r <= DATA_RST;
         txByte_r <= DATA_RST;
         ptr_r <= PTR_RST;
         dir_r <= DIR_WRITE;
         masterAck_r <= 1'b0;
         sdaOe_r <= 1'b0;
         sdaOut_r <= 1'b0;
         busBusy_r <= 1'b0;
      end else begin
         state_r <= state_nxt;
         bitCnt_r <= bitCnt_nxt;
         shift_r <= shift_nxt;
         txByte_r <= txByte_nxt;
         ptr_r <= ptr_nxt;
         dir_r <= dir_nxt;
         masterAck_r <= masterAck_nxt;
         sdaOe_r <= sdaOe_nxt;
         sdaOut_r <= sdaOut_nxt;
         busBusy_r <= busBusy_nxt;
      end
   end

   assign sdaOut = sdaOut_r;
   assign sdaOe = sdaOe_r;
   assign ownAddr = ownAddr_r;
   assign addrValid = addrValid_r;
   assign busBusy = busBusy_r;
   assign regWrStrobe = wrStrobe_r;
   assign regWrPtr = wrPtr_r;
   assign regWrData = wrData_r;
   assign regPtr = ptr_r;

endmodule

`default_nettype wire

// *** tb/pmbtrp_host.sv ***
`timescale 1ns/100ps
`default_nettype none

module pmbtrp_host (
   input wire logic clk,
   input wire logic sdaWire,
   output var logic scl,
   output var logic sdaDrive
);
   // half scl period in clk cycles
   int hp = 125;
   initial begin
      scl = 1'b1;
      sdaDrive = 1'b0;
   end
   task automatic tick(input int n);
      repeat (n) @(negedge clk);
   endtask
   // also serves as repeated start
   task automatic start();
      sdaDrive = 1'b0;
      tick(hp);
      scl = 1'b1;
      tick(hp);
      sdaDrive = 1'b1;
      tick(hp);
      scl = 1'b0;
   endtask
   task automatic stop();
      sdaDrive = 1'b1;
      tick(hp);
      scl = 1'b1;
      tick(hp);
      sdaDrive = 1'b0;
      tick(hp);
   endtask
   task automatic bitx(input logic b, output logic r);
      sdaDrive = ~b;
      tick(hp);
      scl = 1'b1;
      tick(hp);
      r = sdaWire;
      scl = 1'b0;
   endtask
   // msb first, then ack slot; ackIn 1 releases (nack)
   task automatic xfer(input logic [7:0] tx, input logic ackIn, output logic [7:0] rx, output logic ackOut);
      for (int i = 7; i >= 0; i--) bitx(tx[i], rx[i]);
      bitx(ackIn, ackOut);
   endtask
endmodule

`default_nettype wire

// *** tb/pmbtrp_props.sv ***
`timescale 1ns/100ps
`default_nettype none

module pmbtrp_props
   import pmbtrp_pkg::*;
(
   input wire logic clk,
   input wire logic reset_n,
   input wire logic sclIn,
   input wire logic sdaIn,
   input wire logic sdaOut,
   input wire logic sdaOe,
   input wire logic addrValid,
   input wire logic [ADDR_W-1:0] ownAddr,
   input wire logic busBusy,
   input wire logic regWrStrobe,
   input wire logic [PTR_W-1:0] regWrPtr,
   input wire logic [PTR_W-1:0] regPtr
);
   default clocking cb @(posedge clk);
   endclocking
   default disable iff (!reset_n);

   AST_QUIET_UNTIL_VALID: assert property (!addrValid |-> !sdaOe)
      else $error("sda driven before address valid");
   AST_PREFIX: assert property (addrValid |-> ownAddr[6:4] == 3'h1)
      else $error("address prefix wrong");
   AST_ADDR_FROZEN: assert property (addrValid && $past(addrValid) |-> $stable(ownAddr))
      else $error("own address moved after capture");
   AST_OPEN_DRAIN: assert property (sdaOe |-> sdaOut == 1'b0)
      else $error("sda driven high");
   AST_DRIVE_ON_LOW_SCL: assert property ($changed(sdaOe) |-> !sclIn)
      else $error("sda changed while scl high");
   AST_STROBE_GAP: assert property (regWrStrobe |=> !regWrStrobe [*8])
      else $error("store strobe too long");
   AST_STROBE_PTR: assert property (regWrStrobe |-> regWrPtr == regPtr && busBusy)
      else $error("store not at held pointer");
   AST_PTR_HELD_IDLE: assert property (!busBusy ##1 !busBusy |-> $stable(regPtr))
      else $error("pointer moved while idle");
   AST_START_BUSY: assert property (sclIn && $past(sclIn) && $past(sdaIn) && !sdaIn |-> ##[1:3] busBusy)
      else $error("start not seen");
   AST_STOP_IDLE: assert property (sclIn && $past(sclIn) && !$past(sdaIn) && sdaIn |-> ##[1:3] !busBusy)
      else $error("stop not seen");
   AST_OE_IN_PACKET: assert property (sdaOe |-> busBusy)
      else $error("sda driven outside packet");

   cover property (regWrStrobe);
   cover property ($rose(sdaOe));
   cover property ($fell(busBusy));
endmodule

bind pmbtrp_target pmbtrp_props props_u (.clk, .reset_n, .sclIn, .sdaIn, .sdaOut, .sdaOe, .addrValid,
   .ownAddr, .busBusy, .regWrStrobe, .regWrPtr, .regPtr);

`default_nettype wire

// *** tb/testbench.sv ***
`timescale 1ns/100ps
`default_nettype none

module testbench
   import pmbtrp_pkg::*;
();
   logic clk = 1'b0;
   logic reset_n = 1'b0;
   logic supplyUndervoltageLockout = 1'b1;
   logic [STRAP_W-1:0] addrStrap = 4'h0;
   logic sclIn, sdaIn, sdaOut, sdaOe, hostOe, addrValid, busBusy, regWrStrobe, ak;
   logic [ADDR_W-1:0] ownAddr, me;
   logic [7:0] regWrPtr, regWrData, regPtr, rx, p1;
   logic [7:0] mem [256];
   logic [31:0] rnd;
   int seed, fails, checks;
   int strobes = 0;

   always #2 clk = ~clk;
   // wired-and with pull-up
   assign sdaIn = ~(sdaOe | hostOe);

   pmbtrp_target dut_u (.clk, .reset_n, .sclIn, .sdaIn, .sdaOut, .sdaOe, .supplyUndervoltageLockout,
      .addrStrap, .ownAddr, .addrValid, .busBusy, .regWrStrobe, .regWrPtr, .regWrData, .regPtr);
   pmbtrp_host host_u (.clk, .sdaWire(sdaIn), .scl(sclIn), .sdaDrive(hostOe));

   // one-cycle store pulse spans exactly one falling edge
   always @(negedge clk) begin
      if (regWrStrobe === 1'b1) strobes++;
   end

   task automatic wrap_up();
      $display("checks %0d fails %0d", checks, fails);
      if (fails == 0 && checks > 0) $display("Testbench passed");
      else $display("Testbench failed");
      $finish;
   endtask
   task automatic cmpByte(input string what, input logic [7:0] e, input logic [7:0] g);
      checks++;
      if (g !== e) begin
         fails++;
         $display("[FAIL] %s expected %h seen %h", what, e, g);
      end
   endtask
   task automatic cmpBit(input string what, input logic e, input logic g);
      checks++;
      if (g !== e) begin
         fails++;
         $display("[FAIL] %s expected %b seen %b", what, e, g);
      end
   endtask
   function automatic logic [ADDR_W-1:0] expOwn(input logic [STRAP_W-1:0] s);
      return {ADDR_PREFIX, s};
   endfunction
   // ack level expected on the wire: 0 only for our own seven-bit address
   function automatic logic expAck(input logic [7:0] b);
      return (b[7:1] == me) ? 1'b0 : 1'b1;
   endfunction
   task automatic sendAddr(input logic [7:0] b);
      host_u.start();
      host_u.xfer(b, 1'b1, rx, ak);
      cmpBit("addr ack", expAck(b), ak);
   endtask
   task automatic setPtr(input logic [7:0] p);
      sendAddr({me, DIR_WRITE});
      host_u.xfer(p, 1'b1, rx, ak);
      cmpBit("ptr ack", 1'b0, ak);
   endtask
   task automatic wrReg(input logic [7:0] p, input logic [7:0] d, input logic extra);
      int s0;
      s0 = strobes;
      setPtr(p);
      host_u.xfer(d, 1'b1, rx, ak);
      cmpBit("data ack", 1'b0, ak);
      if (extra) begin
         host_u.xfer(~d, 1'b1, rx, ak);
         cmpBit("extra data ack", 1'b1, ak);
      end
      host_u.stop();
      cmpByte("store count", 8'h01, 8'(strobes - s0));
      mem[p] = d;
      cmpByte("stored byte", d, regWrData);
      cmpByte("pointer", p, regPtr);
   endtask
   task automatic readData(input logic [7:0] p, input logic mAck);
      host_u.xfer(8'hff, mAck, rx, ak);
      cmpByte("read data", mem[p], rx);
   endtask

   initial begin
      repeat (95000) @(posedge clk);
      fails++;
      wrap_up();
   end

   initial begin
      seed = 32'hde11;
      repeat (2) @(negedge clk);
      reset_n = 1'b1;
      rnd = $random(seed);
      addrStrap = rnd[3:0];
      repeat (4) @(negedge clk);
      cmpBit("valid in lockout", 1'b0, addrValid);
      addrStrap = rnd[7:4];
      me = expOwn(rnd[7:4]);
      supplyUndervoltageLockout = 1'b0;
      repeat (4) @(negedge clk);
      addrStrap = ~rnd[7:4];
      repeat (4) @(negedge clk);
      cmpByte("own addr", {1'b0, me}, {1'b0, ownAddr});
      $display("test done: strap");
      rnd = $random(seed);
      wrReg(8'hff, rnd[7:0], 1'b1);
      p1 = rnd[15:8];
      wrReg(p1, rnd[23:16], 1'b0);
      $display("test done: writes");
      setPtr(p1);
      sendAddr({me, DIR_READ});
      readData(p1, 1'b0);
      readData(p1, 1'b1);
      host_u.stop();
      $display("test done: combined read");
      setPtr(8'hff);
      host_u.stop();
      sendAddr({me ^ 7'h01, DIR_WRITE});
      host_u.xfer(8'h00, 1'b1, rx, ak);
      cmpBit("foreign byte ack", 1'b1, ak);
      host_u.stop();
      sendAddr(8'hf0);
      host_u.stop();
      cmpByte("held pointer", 8'hff, regPtr);
      host_u.hp = 313;
      sendAddr({me, DIR_READ});
      readData(8'hff, 1'b1);
      host_u.stop();
      host_u.hp = 1250;
      sendAddr({me, DIR_WRITE});
      host_u.stop();
      cmpByte("pointer kept", 8'hff, regPtr);
      $display("test done: stop separated");
      cmpByte("total stores", 8'h02, 8'(strobes));
      wrap_up();
   end
endmodule

`default_nettype wire
